// *** krc_pkg.sv ***
// Shared constants and types for the knock response controller
package krc_pkg;
    localparam int KRC_W = 12;
    localparam logic [11:0] KRC_IDLE = 12'h000;
    localparam logic [1:0] KRC_MODE_MEAS = 2'h0;
    localparam logic [1:0] KRC_MODE_DIAG = 2'h1;
    localparam logic [1:0] KRC_MODE_KNOCK = 2'h2;
    localparam logic [1:0] KRC_MODE_NONE = 2'h3;
    localparam int KRC_GAIN_FRAC = 4;
    localparam int KRC_SYNC_PULSES = 2;

    typedef struct packed {
        logic [11:0] retard_thr;
        logic [11:0] stop_thr;
        logic [7:0] gain;
        logic [11:0] ramp;
        logic [11:0] ceiling;
    } krc_cfg_s;

    typedef struct packed {
        logic shed;
        logic stop;
        logic knock;
        logic [11:0] retard;
    } krc_out_s;

    typedef enum logic [3:0] {
        KRC_ST_IDLE = 4'b0001,
        KRC_ST_SYNC = 4'b0010,
        KRC_ST_RUN = 4'b0100,
        KRC_ST_DIAG = 4'b1000
    } krc_state_e;
endpackage : krc_pkg

// *** krc_sync3.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module krc_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pin side
    input wire logic din,
    // Clocked side
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Only change once stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout <= 1'b0;
        end else if (s2_q == s3_q) begin
            dout <= s3_q;
        end
    end
endmodule : krc_sync3

// *** krc_ctrl.sv ***
// Knock response decision logic: retard, load shed, stop, modes, indicators
`timescale 1ns/10ps

// Summary of operation
// - One retard command feeds both current-loop and voltage analog outputs together.
// - Retard stays idle until intensity exceeds retard threshold, then rises.
// - Retard increase is scaled by the host retard gain.
// - Without knock, retard falls toward idle by the release ramp step.
// - Retard command is clamped at the configured ceiling.
// - Load shed asserts when retard sits at ceiling and knock persists.
// - Load shed drops as soon as knocking stops.
// - Stop output asserts when intensity exceeds independent stop threshold.
// - Host selects one of measurement, diagnostics or knock detection modes.
// - Diagnostics mode drives outputs from host test values, no analysis.
// - Knock detection acts only after sync to ignition reference pulses.
// - Each binary output state is mirrored on its own indicator.
// - Knock detection mode flags sensor signals judged faulty.
// - Measurement mode only reports sensor data, acts on no threshold.
// - Below minimum speed in knock detection mode flag low-speed error and keep control inactive.
// - Host command clears stored peak knock intensity.
module krc_ctrl #(
    parameter int W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host configuration
    input wire logic [1:0] mode,
    input wire krc_pkg::krc_cfg_s cfg,
    input wire krc_pkg::krc_out_s diag_val,
    input wire logic peak_clr,
    input wire logic bad_sensor_en,
    // Sensor analysis side
    input wire logic [W-1:0] intensity,
    input wire logic intensity_vld,
    input wire logic sensor_fault,
    input wire logic speed_low,
    // Ignition reference pin
    input wire logic ign_pulse,
    // Outputs to ignition controller and master control
    output logic [W-1:0] retard_current,
    output logic [W-1:0] retard_voltage,
    output logic knock_out,
    output logic shed_out,
    output logic stop_out,
    // Indicators and status
    output logic led_knock,
    output logic led_shed,
    output logic led_stop,
    output logic err_low_speed,
    output logic err_bad_sensor,
    output logic synced,
    output logic [W-1:0] peak_value,
    output logic [W-1:0] meas_value
);
    import krc_pkg::*;

    krc_state_e state_q;
    krc_state_e state_d;
    logic ign_s;
    logic ign_prev_q;
    logic ign_rise;
    logic [1:0] pulse_cnt_q;
    logic [W-1:0] retard_q;
    logic knock_q;
    logic shed_q;
    logic stop_q;
    logic [W+7:0] step;
    logic [W+8:0] sum;
    logic above_retard;
    logic above_stop;

    // Ignition pulse crosses in from a pin
    krc_sync3 u_ign_sync (
        .clk(clk),
        .rst(rst),
        .din(ign_pulse),
        .dout(ign_s)
    );

    assign ign_rise = ign_s & ~ign_prev_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ign_prev_q <= 1'b0;
        end else begin
            ign_prev_q <= ign_s;
        end
    end

    // Mode state machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            KRC_ST_IDLE: begin
                if (mode == KRC_MODE_DIAG) begin
                    state_d = KRC_ST_DIAG;
                end else if (mode == KRC_MODE_KNOCK) begin
                    state_d = KRC_ST_SYNC;
                end
            end
            KRC_ST_SYNC: begin
                if (mode != KRC_MODE_KNOCK) begin
                    state_d = KRC_ST_IDLE;
                end else if (ign_rise && pulse_cnt_q == 2'(KRC_SYNC_PULSES - 1)) begin
                    state_d = KRC_ST_RUN;
                end
            end
            KRC_ST_RUN: begin
                if (mode != KRC_MODE_KNOCK) begin
                    state_d = KRC_ST_IDLE;
                end
            end
            KRC_ST_DIAG: begin
                if (mode != KRC_MODE_DIAG) begin
                    state_d = KRC_ST_IDLE;
                end
            end
            default: state_d = KRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= KRC_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Count reference pulses while acquiring sync
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_cnt_q <= 2'h0;
        end else if (state_q != KRC_ST_SYNC) begin
            pulse_cnt_q <= 2'h0;
        end else if (ign_rise) begin
            pulse_cnt_q <= pulse_cnt_q + 2'h1;
        end
    end

    assign synced = (state_q == KRC_ST_RUN);

    // Independent thresholds
    assign above_retard = intensity > cfg.retard_thr;
    assign above_stop = intensity > cfg.stop_thr;

    // Gain in fixed point, low bits fractional
    assign step = (W + 8)'(((W + 8)'(intensity - cfg.retard_thr) * (W + 8)'(cfg.gain)) >> KRC_GAIN_FRAC);
    assign sum = (W + 9)'(retard_q) + (W + 9)'(step);

    // Retard command, evaluated once per engine-cycle result
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            retard_q <= KRC_IDLE;
        end else if (!synced || speed_low) begin
            retard_q <= KRC_IDLE;
        end else if (intensity_vld) begin
            if (above_retard) begin
                // Saturating add so a large gain cannot wrap past the clamp
                if (sum > (W + 9)'(cfg.ceiling)) begin
                    retard_q <= cfg.ceiling;
                end else begin
                    retard_q <= sum[W-1:0];
                end
            end else if (retard_q > cfg.ramp) begin
                retard_q <= retard_q - cfg.ramp;
            end else begin
                retard_q <= KRC_IDLE;
            end
        end
    end

    // Binary decisions
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            knock_q <= 1'b0;
            shed_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (!synced || speed_low) begin
            knock_q <= 1'b0;
            shed_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (intensity_vld) begin
            knock_q <= above_retard;
            // Shed only while knocking persists at the ceiling
            shed_q <= above_retard && (retard_q >= cfg.ceiling);
            stop_q <= above_stop;
        end
    end

    // Output drivers; diagnostics bypasses all analysis
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            retard_current <= KRC_IDLE;
            retard_voltage <= KRC_IDLE;
            knock_out <= 1'b0;
            shed_out <= 1'b0;
            stop_out <= 1'b0;
        end else if (state_q == KRC_ST_DIAG) begin
            retard_current <= diag_val.retard;
            retard_voltage <= diag_val.retard;
            knock_out <= diag_val.knock;
            shed_out <= diag_val.shed;
            stop_out <= diag_val.stop;
        end else begin
            retard_current <= retard_q;
            retard_voltage <= retard_q;
            knock_out <= knock_q;
            shed_out <= shed_q;
            stop_out <= stop_q;
        end
    end

    // Indicators track the outputs one for one
    assign led_knock = knock_out;
    assign led_shed = shed_out;
    assign led_stop = stop_out;

    // Error flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_low_speed <= 1'b0;
            err_bad_sensor <= 1'b0;
        end else begin
            err_low_speed <= (state_q == KRC_ST_RUN || state_q == KRC_ST_SYNC) && speed_low;
            err_bad_sensor <= synced && bad_sensor_en && sensor_fault;
        end
    end

    // Peak and measurement reporting; a new peak wins over a clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            peak_value <= KRC_IDLE;
            meas_value <= KRC_IDLE;
        end else begin
            if (intensity_vld && (state_q == KRC_ST_RUN || mode == KRC_MODE_MEAS)) begin
                meas_value <= intensity;
            end
            if (intensity_vld && (state_q == KRC_ST_RUN || mode == KRC_MODE_MEAS)
                && intensity > peak_value) begin
                peak_value <= intensity;
            end else if (peak_clr) begin
                peak_value <= KRC_IDLE;
            end
        end
    end
endmodule : krc_ctrl

// *** krc_ign_model.sv ***
// Ignition reference source standing in for the ignition controller
`timescale 1ns/10ps
module krc_ign_model (
    // Clock and enable
    input wire logic clk,
    input wire logic run,
    // Reference pin
    output logic ign_pulse
);
    logic [3:0] cnt_q;
    // Pin rests low outside a run, so no stray edge can fake sync
    always_ff @(posedge clk) begin
        cnt_q <= run ? cnt_q + 4'h1 : 4'h0;
        ign_pulse <= run && cnt_q[3];
    end
endmodule : krc_ign_model

// *** krc_ctrl_sva.sv ***
// Port assertions for the knock response controller
`timescale 1ns/10ps
module krc_ctrl_sva (
    // Clock, reset, inputs
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mode,
    input wire krc_pkg::krc_cfg_s cfg,
    input wire krc_pkg::krc_out_s diag_val,
    input wire logic [11:0] intensity,
    input wire logic intensity_vld,
    input wire logic speed_low,
    // Outputs
    input wire logic [11:0] retard_current,
    input wire logic [11:0] retard_voltage,
    input wire logic knock_out,
    input wire logic shed_out,
    input wire logic stop_out,
    input wire logic led_knock,
    input wire logic led_shed,
    input wire logic led_stop,
    input wire logic err_low_speed,
    input wire logic synced
);
    import krc_pkg::*;
    logic take, kn_hit, st_hit, run_k;
    logic [14:0] outs;
    assign run_k = synced && !speed_low && mode == KRC_MODE_KNOCK;
    assign take = intensity_vld && run_k;
    assign kn_hit = intensity > cfg.retard_thr;
    assign st_hit = intensity > cfg.stop_thr;
    assign outs = {knock_out, shed_out, stop_out, retard_current};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_both_analog: assert property (retard_current == retard_voltage)
        else $error("analog pair differs");
    a_led_copy: assert property ({led_knock, led_shed, led_stop} == outs[14:12])
        else $error("indicator differs");
    a_knock_level: assert property (take |-> ##2 knock_out == $past(kn_hit, 2))
        else $error("knock output wrong");
    a_stop_level: assert property (take |-> ##2 stop_out == $past(st_hit, 2))
        else $error("stop output wrong");
    a_shed_release: assert property (take && !kn_hit |-> ##2 !shed_out)
        else $error("shed stayed on");
    a_quiet_unsynced: assert property ((!synced && mode != KRC_MODE_DIAG) [*3] |-> outs == 15'h0)
        else $error("output while unsynced");
    a_slow_quiet: assert property ((mode == KRC_MODE_KNOCK && speed_low) [*4] |-> outs == 15'h0 && err_low_speed)
        else $error("low speed ignored");
    a_diag_follow: assert property ((mode == KRC_MODE_DIAG && $stable(diag_val)) [*4]
        |-> outs == {diag_val.knock, diag_val.shed, diag_val.stop, diag_val.retard})
        else $error("diag value lost");
    a_hold_between: assert property ((run_k && !intensity_vld) [*3] |-> $stable(outs))
        else $error("output moved idle");
endmodule : krc_ctrl_sva

bind krc_ctrl krc_ctrl_sva chk_u (.*);

// *** krc_ctrl_tb_top.sv ***
// Self-checking bench for the knock response controller
`timescale 1ns/10ps
module krc_ctrl_tb_top;
    import krc_pkg::*;
    logic clk, rst, peak_clr, bad_sensor_en, intensity_vld, sensor_fault, speed_low, ign_pulse, run;
    logic knock_out, shed_out, stop_out, led_knock, led_shed, led_stop, err_low_speed, err_bad_sensor, synced;
    logic [1:0] mode;
    logic [11:0] intensity, retard_current, retard_voltage, peak_value, meas_value;
    krc_cfg_s cfg;
    krc_out_s diag_val;
    krc_out_s dpat[2] = '{'{1'b1, 1'b0, 1'b1, 12'h5a5}, '{1'b0, 1'b1, 1'b0, 12'habc}};
    // Gain 32 is x2, ceiling 300, ramp 10
    logic [11:0] vals[5] = '{12'h096, 12'h190, 12'h190, 12'h384, 12'h032};
    logic [14:0] exps[5] = '{15'h4064, 15'h412c, 15'h612c, 15'h712c, 15'h0122};
    int fails, check_count;
    krc_ctrl dut_u (.*);
    krc_ign_model ign_u (.*);
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic fire(input logic [11:0] v);
        intensity = v;
        intensity_vld = 1'b1;
        step(1);
        intensity_vld = 1'b0;
        step(1);
    endtask : fire
    function automatic logic [14:0] outs();
        return {knock_out, shed_out, stop_out, retard_current};
    endfunction : outs
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run is under a hundred cycles
    initial begin
        #150000;
        fails++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        {peak_clr, bad_sensor_en, intensity_vld, sensor_fault, speed_low, run} = 6'h00;
        mode = KRC_MODE_NONE;
        cfg = '{12'h064, 12'h320, 8'h20, 12'h00a, 12'h12c};
        diag_val = '0;
        intensity = '0;
        step(16);
        rst = 1'b0;
        chk(outs(), 15'h0);
        mode = KRC_MODE_KNOCK;
        run = 1'b1;
        fire(12'h3ff);
        step(4);
        chk(outs(), 15'h0);
        for (int i = 0; i < 200 && synced !== 1'b1; i++) step(1);
        chk({14'h0, synced}, 15'h1);
        foreach (vals[i]) begin
            fire(vals[i]);
            chk(outs(), exps[i]);
            chk({led_knock, led_shed, led_stop, retard_voltage}, exps[i]);
        end
        sensor_fault = 1'b1;
        bad_sensor_en = 1'b1;
        step(3);
        chk({14'h0, err_bad_sensor}, 15'h1);
        sensor_fault = 1'b0;
        speed_low = 1'b1;
        step(4);
        chk(outs(), 15'h0);
        chk({14'h0, err_low_speed}, 15'h1);
        speed_low = 1'b0;
        mode = KRC_MODE_DIAG;
        foreach (dpat[i]) begin
            diag_val = dpat[i];
            step(5);
            chk(outs(), {diag_val.knock, diag_val.shed, diag_val.stop, diag_val.retard});
        end
        mode = KRC_MODE_MEAS;
        peak_clr = 1'b1;
        step(2);
        peak_clr = 1'b0;
        fire(12'h0c8);
        step(1);
        chk(outs(), 15'h0);
        chk({3'h0, peak_value}, 15'h0c8);
        chk({3'h0, meas_value}, 15'h0c8);
        peak_clr = 1'b1;
        step(2);
        chk({3'h0, peak_value}, 15'h0);
        close_out();
    end
endmodule : krc_ctrl_tb_top
